// ---- inc/adc_readout_pkg.sv ----
// constants and pin carrier for the serial converter readout
// assumes one 20 MHz system clock; host pins arrive asynchronously
package adc_readout_pkg;
	localparam int         NULL_BITS  = 2;
	localparam int         DATA_BITS  = 14;
	localparam int         FRAME_BITS = NULL_BITS + DATA_BITS;
	localparam logic [3:0] CNT_RESET  = 4'h0;
	localparam logic [3:0] CNT_LAST   = 4'(FRAME_BITS - 1);
	localparam logic [13:0] TRIAL_INIT = 14'h2000;
	localparam logic [13:0] WORD_RESET = 14'h0000;

	typedef enum logic [3:0] {
		ST_ACQ  = 4'b0001,
		ST_NULL = 4'b0010,
		ST_DATA = 4'b0100,
		ST_DONE = 4'b1000
	} conv_state_type;

	// host pins plus the analog comparator decision
	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic cmp_hi;
	} pins_type;
endpackage : adc_readout_pkg

// ---- verilog/adc_serial_readout.sv ----
// serial readout and successive-approximation control of a 14-bit converter
// assumes host drives select and serial clock; an analog comparator
// reports whether the input lies above the trial word on trial_o
//
// Contract
// - select held low all frame; its falling edge starts a conversion
// - while select is high the device only tracks the input
// - frame is two null bits then fourteen result bits, MSB first
// - output changes on serial clock falls; host samples on rises
// - serial clock both shifts data and steps the conversion
// - result is sent as two's complement
// - bits sent are those of the current conversion, no latency
`timescale 1ns/1ps
module adc_serial_readout (
	input  wire logic                     sys_clk_i,   // 20 MHz clock
	input  wire logic                     reset_n_i,   // sync reset
	input  wire adc_readout_pkg::pins_type pins_i,     // async pins
	output logic                          dout_o,      // serial data
	output logic                          dout_oe_n_o, // low = driving
	output logic                          acq_o,       // tracking input
	output logic [13:0]                   trial_o,     // to the DAC
	output logic [13:0]                   result_o,    // last result
	output logic                          done_o       // result pulse
);
	import adc_readout_pkg::*;

	logic           cs_meta_ff, cs_sync_ff, cs_prev_ff;
	logic           ck_meta_ff, ck_sync_ff, ck_prev_ff;
	logic           cmp_meta_ff, cmp_sync_ff;
	conv_state_type state_ff, nxt_state;
	logic [3:0]     cnt_ff;
	logic [13:0]    mask_ff;
	logic [13:0]    kept_w;
	logic           cs_fall_w, sclk_fall_w, last_bit_w, bit_out_w;

	// pins are async to sys_clk: two flops before any logic looks
	always_ff @(posedge sys_clk_i) begin
		cs_meta_ff  <= pins_i.cs_n;
		cs_sync_ff  <= cs_meta_ff;
		cs_prev_ff  <= cs_sync_ff;
		ck_meta_ff  <= pins_i.sclk;
		ck_sync_ff  <= ck_meta_ff;
		ck_prev_ff  <= ck_sync_ff;
		cmp_meta_ff <= pins_i.cmp_hi;
		cmp_sync_ff <= cmp_meta_ff;
	end

	assign cs_fall_w   = cs_prev_ff & ~cs_sync_ff;
	assign sclk_fall_w = ck_prev_ff & ~ck_sync_ff & ~cs_sync_ff;
	// comparator high keeps the trial bit set
	assign kept_w      = cmp_sync_ff ? trial_o : (trial_o & ~mask_ff);
	assign last_bit_w  = mask_ff[0];
	// offset-binary MSB inverted gives the two's complement sign
	assign bit_out_w   = mask_ff[13] ? ~cmp_sync_ff : cmp_sync_ff;

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_ACQ:  if (cs_fall_w) nxt_state = ST_NULL;
			ST_NULL: if (sclk_fall_w) nxt_state = ST_DATA;
			ST_DATA: if (sclk_fall_w && last_bit_w) nxt_state = ST_DONE;
			ST_DONE: nxt_state = ST_DONE;
		endcase
		if (cs_sync_ff)
			nxt_state = ST_ACQ;
	end

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			state_ff <= ST_ACQ;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// frame bit counter, one step per serial clock fall until ST_DONE
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i || cs_fall_w) begin
			cnt_ff <= CNT_RESET;
		end else if (sclk_fall_w && state_ff != ST_DONE) begin
			cnt_ff <= cnt_ff + 4'h1;
		end
	end

	// sar stepping: one decision per serial clock fall in ST_DATA
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			trial_o <= WORD_RESET;
			mask_ff <= TRIAL_INIT;
		end else if (cs_fall_w) begin
			trial_o <= TRIAL_INIT;
			mask_ff <= TRIAL_INIT;
		end else if (state_ff == ST_DATA && sclk_fall_w) begin
			trial_o <= kept_w | (mask_ff >> 1);
			mask_ff <= mask_ff >> 1;
		end
	end

	// serial output: null bits, then each decision as it is made
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i || cs_sync_ff) begin
			dout_o      <= 1'b0;
			dout_oe_n_o <= 1'b1;
		end else if (cs_fall_w) begin
			dout_o      <= 1'b0;
			dout_oe_n_o <= 1'b0;
		end else if (state_ff == ST_DATA && sclk_fall_w) begin
			dout_o      <= bit_out_w;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			acq_o    <= 1'b1;
			result_o <= WORD_RESET;
			done_o   <= 1'b0;
		end else begin
			acq_o  <= (nxt_state == ST_ACQ);
			done_o <= state_ff == ST_DATA && sclk_fall_w && last_bit_w;
			if (state_ff == ST_DATA && sclk_fall_w && last_bit_w)
				result_o <= {~kept_w[13], kept_w[12:0]};
		end
	end

	sequence s_msb_decide;
		state_ff == ST_DATA && sclk_fall_w && mask_ff[13];
	endsequence

	sequence s_low_decide;
		state_ff == ST_DATA && sclk_fall_w && !mask_ff[13];
	endsequence

	sequence s_last_decide;
		state_ff == ST_DATA && sclk_fall_w && last_bit_w;
	endsequence

	// frame-level checks: a cut frame must leave no result behind,
	// and a finished frame must freeze the line until select rises
	a_result_load: assert property (@(posedge sys_clk_i)
		disable iff (!reset_n_i)
		s_last_decide |=> done_o && result_o == {~trial_o[13], trial_o[12:0]})
		else $error("result not the two's complement of the last trial");
	a_done_pulse: assert property (@(posedge sys_clk_i)
		disable iff (!reset_n_i)
		done_o |=> !done_o)
		else $error("done lasted more than one cycle");
	a_done_state: assert property (@(posedge sys_clk_i)
		disable iff (!reset_n_i)
		$rose(done_o) |-> state_ff == ST_DONE)
		else $error("done without frame end");
	a_abort_quiet: assert property (@(posedge sys_clk_i)
		disable iff (!reset_n_i)
		cs_sync_ff |=> !done_o)
		else $error("result completed while select high");
	a_hold_trial: assert property (@(posedge sys_clk_i)
		disable iff (!reset_n_i)
		cs_sync_ff |=> $stable(trial_o) && $stable(mask_ff))
		else $error("conversion stepped while tracking");
	a_done_frozen: assert property (@(posedge sys_clk_i)
		disable iff (!reset_n_i)
		state_ff == ST_DONE && !cs_sync_ff |=> $stable(dout_o))
		else $error("output moved after the last bit");
	a_cnt_hold: assert property (@(posedge sys_clk_i)
		disable iff (!reset_n_i)
		!sclk_fall_w && !cs_fall_w |=> $stable(cnt_ff))
		else $error("bit count moved off a clock fall");
	a_mask_onehot: assert property (@(posedge sys_clk_i)
		disable iff (!reset_n_i)
		state_ff == ST_DATA |-> $onehot(mask_ff))
		else $error("trial mask not one-hot");
	a_oe_frame: assert property (@(posedge sys_clk_i)
		disable iff (!reset_n_i)
		state_ff != ST_ACQ |-> !dout_oe_n_o)
		else $error("output not driven during frame");
	a_acq_match: assert property (@(posedge sys_clk_i)
		disable iff (!reset_n_i)
		acq_o == (state_ff == ST_ACQ))
		else $error("tracking flag disagrees with state");
	a_null_out: assert property (@(posedge sys_clk_i)
		disable iff (!reset_n_i)
		state_ff == ST_NULL |-> !dout_oe_n_o && !acq_o)
		else $error("null bits not driven");
	a_idle_out: assert property (@(posedge sys_clk_i)
		disable iff (!reset_n_i)
		state_ff == ST_ACQ |-> !dout_o)
		else $error("data shown while tracking");
	a_cs_restart: assert property (@(posedge sys_clk_i)
		disable iff (!reset_n_i)
		cs_fall_w |=> cnt_ff == CNT_RESET && mask_ff == TRIAL_INIT)
		else $error("frame state not cleared at select fall");

	a_start_conv: assert property (@(posedge sys_clk_i)
		disable iff (!reset_n_i)
		cs_fall_w |=> state_ff == ST_NULL && !acq_o
			&& trial_o == TRIAL_INIT && !dout_oe_n_o)
		else $error("conversion did not start on select fall");
	a_track_idle: assert property (@(posedge sys_clk_i)
		disable iff (!reset_n_i)
		cs_sync_ff |=> acq_o && dout_oe_n_o && state_ff == ST_ACQ)
		else $error("not tracking while select high");
	a_null_lead: assert property (@(posedge sys_clk_i)
		disable iff (!reset_n_i)
		state_ff == ST_NULL |-> !dout_o && cnt_ff <= 4'h1)
		else $error("null bit not zero");
	a_frame_len: assert property (@(posedge sys_clk_i)
		disable iff (!reset_n_i)
		$rose(done_o) |-> cnt_ff == CNT_LAST)
		else $error("frame length wrong");
	a_dout_falls: assert property (@(posedge sys_clk_i)
		disable iff (!reset_n_i)
		!sclk_fall_w && !cs_fall_w && !cs_sync_ff |=> $stable(dout_o))
		else $error("output changed off a clock fall");
	a_sar_step: assert property (@(posedge sys_clk_i)
		disable iff (!reset_n_i)
		state_ff == ST_DATA && sclk_fall_w |=>
			mask_ff == ($past(mask_ff) >> 1))
		else $error("conversion did not step on clock fall");
	a_sign_bit: assert property (@(posedge sys_clk_i)
		disable iff (!reset_n_i)
		s_msb_decide |=> dout_o == !$past(cmp_sync_ff))
		else $error("sign bit not two's complement");
	a_no_latency: assert property (@(posedge sys_clk_i)
		disable iff (!reset_n_i)
		s_low_decide |=> dout_o == $past(cmp_sync_ff))
		else $error("output bit not the current decision");
endmodule : adc_serial_readout

// ---- testbench/host_model.sv ----
// host model: drives select and serial clock, samples serial data
// assumes the device samples its pins on sys_clk rises
`timescale 1ns/1ps
module host_model (
	input  wire logic        clk_i,  // sys clock
	input  wire logic        dout_i, // device data
	output logic             cs_n_o, // select
	output logic             sclk_o, // idles low
	output logic [15:0]      word_o  // captured bits
);
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		word_o = 16'h0000;
	end
	// h: half period in sys clocks; sel 0 runs the clock unselected
	task automatic frame(input int h, input int n, input bit sel);
		cs_n_o <= ~sel;
		repeat (h) @(posedge clk_i);
		for (int i = 0; i < n; i++) begin
			@(negedge clk_i) word_o = {word_o[14:0], dout_i};
			@(posedge clk_i) sclk_o <= 1'b1;
			repeat (h) @(posedge clk_i);
			sclk_o <= 1'b0;
			repeat (h) @(posedge clk_i);
		end
		cs_n_o <= 1'b1;
		repeat (h) @(posedge clk_i);
	endtask : frame
endmodule : host_model

// ---- testbench/tb_top.sv ----
// self-checking bench for the serial converter readout
// assumes host_model plays the host; comparator modelled here
`timescale 1ns/1ps
module tb_top;
	import adc_readout_pkg::*;
	logic        sys_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [13:0] vin = 14'h0000;
	int          err_count = 0;
	int          total_checks = 0;
	int          dn = 0;
	logic        dout, oe_n, acq, done, cs_n, sclk;
	logic [13:0] trial, result;
	logic [15:0] word;
	pins_type    pins;
	// input sits half a step above vin, so a clean SAR returns vin
	assign pins = '{cs_n: cs_n, sclk: sclk, cmp_hi: vin >= trial};
	always #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (done === 1'b1) dn <= dn + 1;
	adc_serial_readout uut (.sys_clk_i(sys_clk), .reset_n_i(reset_n),
		.pins_i(pins), .dout_o(dout), .dout_oe_n_o(oe_n), .acq_o(acq),
		.trial_o(trial), .result_o(result), .done_o(done));
	host_model host (.clk_i(sys_clk), .dout_i(dout), .cs_n_o(cs_n),
		.sclk_o(sclk), .word_o(word));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic run(input int h, input int n, input bit sel,
		input logic [13:0] v, input int pulses);
		int d0;
		d0 = dn;
		vin <= v;
		fork
			host.frame(h, n, sel);
			begin
				repeat (4 * h) @(negedge sys_clk);
				chk(16'(acq), 16'(!sel));
				chk(16'(oe_n), 16'(!sel));
			end
		join
		chk(16'(acq), 16'h0001);
		chk(16'(dn - d0), 16'(pulses));
	endtask : run
	task automatic t_codes;
		logic [13:0] tbl [5] = '{14'h0000, 14'h3fff, 14'h2000, 14'h1fff,
			14'h2a5c};
		foreach (tbl[i]) begin
			run(5 + 5 * (i % 2), 16, 1'b1, tbl[i], 1);
			chk(word, {2'b00, tbl[i] ^ 14'h2000});
			chk({{2{word[13]}}, word[13:0]},
				{{2{~tbl[i][13]}}, tbl[i] ^ 14'h2000});
			chk(16'(result), 16'(tbl[i] ^ 14'h2000));
		end
		$display("t_codes done");
	endtask : t_codes
	task automatic t_abort;
		run(5, 6, 1'b1, 14'h1234, 0);
		chk(16'(result), 16'h0a5c);
		run(5, 16, 1'b1, 14'h0abc, 1);
		chk(word, 16'h2abc);
		$display("t_abort done");
	endtask : t_abort
	task automatic t_idle;
		run(5, 16, 1'b0, 14'h3000, 0);
		chk(word, 16'h0000);
		chk(16'(result), 16'h2abc);
		$display("t_idle done");
	endtask : t_idle
	task automatic final_report;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : final_report
	initial begin
		repeat (10) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk(16'(result), 16'h0000);
		t_codes;
		t_abort;
		t_idle;
		final_report;
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		err_count++;
		final_report;
	end
endmodule : tb_top
